// File: core/iwh_ctrl.sv
// interrupt, watchdog and power-down control of a small core
// assumes core strobes on clk_i; pins arrive asynchronously
`timescale 1ns/1ps
module iwh_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core sequencer
  input wire logic phase_two_pulse_i,
  input wire logic return_from_irq_instr_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic clear_watchdog_first_i,
  input wire logic clear_watchdog_second_i,
  input wire logic halt_instr_i,
  input wire logic stack_full_i,
  input wire logic timer0_ovf_i,
  input wire logic timer1_ovf_i,
  // pins
  input wire logic ext_irq_pin_n_i,
  input wire logic ext_reset_pin_n_i,
  input wire logic wd_rc_osc_i,
  input wire logic [7:0] port_a_i,
  // to the core and pins
  output logic irq_call_o,
  output logic [7:0] irq_vector_o,
  output logic chip_reset_o,
  output logic warm_reset_o,
  output logic sys_osc_stop_o,
  output logic resume_o,
  output logic osc_output_pin_o
);

  // =====================================================
  // declarations
  iwh_pkg::iwh_state_e state;
  logic [10:0] sync1, sync2, sync3, filt, filt_q;
  logic ext_fall, rc_rise, ext_rst_act, pa_wake;
  logic [1:0] div_cnt;
  logic instr_tick;
  logic master_irq_enable;
  logic [2:0] irq_enable, irq_flag, set_vec, pending, grant;
  logic take;
  logic [7:0] watchdog_select_reg;
  logic [15:0] opt;
  logic timeout_flag, powerdown_flag;
  logic [7:0] wd_base;
  logic [6:0] wd_presc;
  logic first_seen, second_seen;
  logic wd_en, wd_src, clr_done, wd_clear, wd_ovf;
  logic halt_go, wake_evt;
  logic [10:0] wake_cnt;
  logic req, wr, blk_rst;

  function automatic logic hit(input logic [7:0] adr,
                               input logic [5:0] idx);
    hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  function automatic logic [7:0] vec_of(input logic [2:0] g);
    if (g[iwh_pkg::SRC_EXT]) begin
      vec_of = iwh_pkg::VEC_EXT;
    end else if (g[iwh_pkg::SRC_T0]) begin
      vec_of = iwh_pkg::VEC_T0;
    end else begin
      vec_of = iwh_pkg::VEC_T1;
    end
  endfunction

  // =====================================================
  // pin synchronisers and edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= iwh_pkg::PIN_IDLE;
      sync2 <= iwh_pkg::PIN_IDLE;
      sync3 <= iwh_pkg::PIN_IDLE;
      filt <= iwh_pkg::PIN_IDLE;
      filt_q <= iwh_pkg::PIN_IDLE;
    end else begin
      sync1 <= {wd_rc_osc_i, ext_reset_pin_n_i, ext_irq_pin_n_i, port_a_i};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= (sync2 & sync3) | (filt & (sync2 | sync3));
      filt_q <= filt;
    end
  end

  assign ext_fall = filt_q[iwh_pkg::PIN_EXT] & ~filt[iwh_pkg::PIN_EXT];
  assign rc_rise = ~filt_q[iwh_pkg::PIN_RC] & filt[iwh_pkg::PIN_RC];
  assign ext_rst_act = ~filt[iwh_pkg::PIN_RES];
  assign pa_wake = |(filt_q[7:0] & ~filt[7:0] & opt[iwh_pkg::OPT_WAKE_LO +: 8]);

  // =====================================================
  // wishbone slave
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign blk_rst = rst_i | chip_reset_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0;
      if (req && hit(wb_adr_i, iwh_pkg::IDX_ICTL)) begin
        wb_dat_o[7:0] <= {1'b0, irq_flag, irq_enable, master_irq_enable};
      end else if (req && hit(wb_adr_i, iwh_pkg::IDX_WDSEL)) begin
        wb_dat_o[7:0] <= watchdog_select_reg;
      end else if (req && hit(wb_adr_i, iwh_pkg::IDX_STAT)) begin
        wb_dat_o[iwh_pkg::STAT_TMOUT] <= timeout_flag;
        wb_dat_o[iwh_pkg::STAT_PWRDN] <= powerdown_flag;
      end else if (req && hit(wb_adr_i, iwh_pkg::IDX_OPT)) begin
        wb_dat_o[15:0] <= opt;
      end
    end
  end

  // select field plus five user flags
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      watchdog_select_reg <= iwh_pkg::WDSEL_RST;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, iwh_pkg::IDX_WDSEL)) begin
      watchdog_select_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      opt <= iwh_pkg::OPT_RST;
    end else if (wr && hit(wb_adr_i, iwh_pkg::IDX_OPT)) begin
      if (wb_sel_i[0]) begin
        opt[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        opt[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // =====================================================
  // interrupt control
  // lowest index wins
  assign pending = irq_flag & irq_enable;
  assign grant = pending & ~3'(pending - 3'h1);
  // decide only on phase two pulse
  assign take = phase_two_pulse_i & (state == iwh_pkg::ST_RUN) & master_irq_enable &
                ~stack_full_i & (|pending) & ~chip_reset_o;
  assign set_vec = {timer1_ovf_i, timer0_ovf_i, ext_fall};

  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      irq_enable <= iwh_pkg::ICTL_RST[3:1];
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, iwh_pkg::IDX_ICTL)) begin
      irq_enable <= wb_dat_i[iwh_pkg::ICTL_EN_LO +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      master_irq_enable <= iwh_pkg::ICTL_RST[iwh_pkg::ICTL_MASTER];
    end else if (take) begin
      master_irq_enable <= 1'b0;
    end else if (return_from_irq_instr_i) begin
      master_irq_enable <= 1'b1;
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, iwh_pkg::IDX_ICTL)) begin
      master_irq_enable <= wb_dat_i[iwh_pkg::ICTL_MASTER];
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      irq_flag <= iwh_pkg::ICTL_RST[6:4];
    end else if (wr && wb_sel_i[0] && hit(wb_adr_i, iwh_pkg::IDX_ICTL)) begin
      irq_flag <= (wb_dat_i[iwh_pkg::ICTL_FL_LO +: 3] & ~(take ? grant : 3'h0)) | set_vec;
    end else begin
      // timer 0 flag set and served
      // timer 1 flag set and served
      irq_flag <= (irq_flag & ~(take ? grant : 3'h0)) | set_vec;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_call_o <= 1'b0;
      irq_vector_o <= 8'h00;
    end else begin
      irq_call_o <= take;
      if (take) begin
        irq_vector_o <= vec_of(grant);
      end
    end
  end

  // =====================================================
  // clock divider and oscillator pin
  // system clock stops in halt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 2'h0;
    end else if (state != iwh_pkg::ST_HALT) begin
      div_cnt <= 2'(div_cnt + 2'h1);
    end
  end

  assign instr_tick = (div_cnt == iwh_pkg::INSTR_LAST) & (state != iwh_pkg::ST_HALT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_output_pin_o <= 1'b0;
      sys_osc_stop_o <= 1'b0;
    end else begin
      // divided clock out in RC mode
      osc_output_pin_o <= opt[iwh_pkg::OPT_RC_OSC] & div_cnt[1];
      sys_osc_stop_o <= (state == iwh_pkg::ST_HALT);
    end
  end

  // =====================================================
  // watchdog
  // clock choice and disable
  assign wd_en = opt[iwh_pkg::OPT_WD_EN];
  assign wd_src = wd_en & (opt[iwh_pkg::OPT_WD_RC] ? rc_rise : instr_tick);
  assign clr_done = wd_en & (opt[iwh_pkg::OPT_PAIRED] ?
                    ((first_seen | clear_watchdog_first_i) &
                     (second_seen | clear_watchdog_second_i)) :
                    clear_watchdog_instr_i);
  assign halt_go = (state == iwh_pkg::ST_RUN) & halt_instr_i & ~chip_reset_o;
  assign wd_clear = ext_rst_act | clr_done | halt_go | chip_reset_o;
  assign wd_ovf = wd_src & ~wd_clear & (wd_base == iwh_pkg::WD_BASE_LAST) &
                  (wd_presc == 7'(~(7'h7f << watchdog_select_reg[2:0])));

  always_ff @(posedge clk_i) begin
    if (blk_rst || wd_clear) begin
      first_seen <= 1'b0;
      second_seen <= 1'b0;
    end else if (wd_en && opt[iwh_pkg::OPT_PAIRED]) begin
      first_seen <= first_seen | clear_watchdog_first_i;
      second_seen <= second_seen | clear_watchdog_second_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || wd_clear) begin
      wd_base <= 8'h00;
      wd_presc <= 7'h00;
    end else if (wd_src) begin
      wd_base <= 8'(wd_base + 8'h01);
      if (wd_base == iwh_pkg::WD_BASE_LAST) begin
        // limit is two to the select
        wd_presc <= wd_ovf ? 7'h00 : 7'(wd_presc + 7'h01);
      end
    end
  end

  // chip or warm reset on overflow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chip_reset_o <= 1'b0;
      warm_reset_o <= 1'b0;
    end else begin
      chip_reset_o <= ext_rst_act | (wd_ovf & (state != iwh_pkg::ST_HALT));
      warm_reset_o <= wd_ovf & (state == iwh_pkg::ST_HALT);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_flag <= 1'b0;
    end else if (wd_ovf) begin
      timeout_flag <= 1'b1;
    end else if (halt_go || clr_done) begin
      timeout_flag <= 1'b0;
    end else if (ext_rst_act && state == iwh_pkg::ST_HALT) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      powerdown_flag <= 1'b0;
    end else if (halt_go) begin
      powerdown_flag <= 1'b1;
    end else if (clr_done) begin
      powerdown_flag <= 1'b0;
    end
  end

  // =====================================================
  // power-down sequencing
  // a flag set wakes only if the flag was clear; reset pin, port A and overflow also wake
  assign wake_evt = ext_rst_act | (|(set_vec & ~irq_flag)) | pa_wake | wd_ovf;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= iwh_pkg::ST_RUN;
      wake_cnt <= 11'h000;
      resume_o <= 1'b0;
    end else begin
      resume_o <= 1'b0;
      case (state)
        iwh_pkg::ST_RUN: begin
          if (halt_go) begin
            state <= iwh_pkg::ST_HALT;
          end
        end
        iwh_pkg::ST_HALT: begin
          if (wake_evt) begin
            state <= iwh_pkg::ST_WAKE;
            wake_cnt <= 11'h000;
          end
        end
        iwh_pkg::ST_WAKE: begin
          if (wake_cnt == iwh_pkg::WAKE_LAST) begin
            state <= iwh_pkg::ST_RUN;
            resume_o <= 1'b1;
          end else begin
            wake_cnt <= 11'(wake_cnt + 11'h001);
          end
        end
        default: begin
          state <= iwh_pkg::ST_RUN;
        end
      endcase
    end
  end

  // =====================================================
  // checks
  logic [10:0] a_wake_len;
  always_ff @(posedge clk_i) begin
    if (rst_i || state != iwh_pkg::ST_WAKE) begin
      a_wake_len <= 11'h000;
    end else begin
      a_wake_len <= 11'(a_wake_len + 11'h001);
    end
  end

  a_wake_length: assert property (
    @(posedge clk_i) disable iff (rst_i)
    resume_o |-> $past(a_wake_len) == 11'(iwh_pkg::WAKE_LEN - 11'h001))
    else $error("wake delay length wrong");

  a_ext_priority: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_call_o && $past(pending[iwh_pkg::SRC_EXT]) |-> irq_vector_o == iwh_pkg::VEC_EXT)
    else $error("external request not first");

  a_t0_vector: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_call_o && !$past(pending[iwh_pkg::SRC_EXT]) && $past(pending[iwh_pkg::SRC_T0]) |->
      irq_vector_o == iwh_pkg::VEC_T0)
    else $error("timer 0 vector wrong");

  a_call_master: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_call_o |-> !master_irq_enable && $past(master_irq_enable))
    else $error("master enable not cleared on call");

  a_call_phase: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_call_o |-> $past(phase_two_pulse_i))
    else $error("call outside phase two pulse");

  a_stack_block: assert property (
    @(posedge clk_i) disable iff (rst_i)
    stack_full_i |=> !irq_call_o)
    else $error("call while stack full");

  a_ext_sets: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ext_fall && !chip_reset_o |=> irq_flag[iwh_pkg::SRC_EXT])
    else $error("external flag not set");

  a_flag_sticky: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(irq_flag[iwh_pkg::SRC_T0]) |-> $past(wr) || $past(chip_reset_o) ||
      (irq_call_o && irq_vector_o == iwh_pkg::VEC_T0))
    else $error("timer 0 flag lost");

  a_halt_flags: assert property (
    @(posedge clk_i) disable iff (rst_i)
    halt_go |=> powerdown_flag && !timeout_flag && state == iwh_pkg::ST_HALT)
    else $error("halt entry flags wrong");

  a_warm_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    warm_reset_o |-> timeout_flag && !chip_reset_o && state == iwh_pkg::ST_WAKE)
    else $error("warm reset without time-out");

  a_return_from_irq_instr_sets: assert property (
    @(posedge clk_i) disable iff (rst_i || chip_reset_o)
    return_from_irq_instr_i && !take |=> master_irq_enable)
    else $error("return did not set master");

endmodule

// File: core/iwh_pkg.sv
// =====================================================
// iwh package: offsets, fields, reset values, timing
// assumes a 50 MHz system clock and a 32-bit bus
package iwh_pkg;
  // register indices; byte address is four times these
  localparam logic [5:0] IDX_WDSEL = 6'h09;
  localparam logic [5:0] IDX_STAT = 6'h0a;
  localparam logic [5:0] IDX_ICTL = 6'h0b;
  localparam logic [5:0] IDX_OPT = 6'h3e;
  // interrupt control fields
  localparam int ICTL_MASTER = 0;
  localparam int ICTL_EN_LO = 1;
  localparam int ICTL_FL_LO = 4;
  localparam int ICTL_RSVD = 7;
  localparam logic [7:0] ICTL_RST = 8'h00;
  // source order is priority order: ext, timer 0, timer 1
  localparam int SRC_EXT = 0;
  localparam int SRC_T0 = 1;
  localparam int SRC_T1 = 2;
  localparam logic [7:0] VEC_EXT = 8'h04;
  localparam logic [7:0] VEC_T0 = 8'h08;
  localparam logic [7:0] VEC_T1 = 8'h0c;
  // watchdog select register
  localparam int WDSEL_LO = 0;
  localparam logic [7:0] WDSEL_RST = 8'h07;
  // status register
  localparam int STAT_PWRDN = 4;
  localparam int STAT_TMOUT = 5;
  // option register
  localparam int OPT_WD_EN = 0;
  localparam int OPT_WD_RC = 1;
  localparam int OPT_PAIRED = 2;
  localparam int OPT_RC_OSC = 3;
  localparam int OPT_WAKE_LO = 8;
  localparam logic [15:0] OPT_RST = 16'h0003;
  // synchronised pin vector
  localparam int PIN_EXT = 8;
  localparam int PIN_RES = 9;
  localparam int PIN_RC = 10;
  localparam logic [10:0] PIN_IDLE = 11'h7ff;
  // watchdog chain
  localparam logic [7:0] WD_BASE_LAST = 8'hff;
  localparam logic [1:0] INSTR_LAST = 2'h3;
  // wake-up dummy delay, in system clock periods
  localparam int CLK_HZ = 50_000_000;
  localparam int WAKE_TSYS = 1024;
  localparam int TSYS_CYC = CLK_HZ / CLK_HZ;
  localparam int WAKE_CYC = WAKE_TSYS * TSYS_CYC;
  localparam logic [10:0] WAKE_LAST = 11'(WAKE_CYC - 1);
  localparam logic [10:0] WAKE_LEN = 11'(WAKE_CYC);
  typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_WAKE} iwh_state_e;
endpackage

// File: tb/interrupt_watchdog_halt_control_tb_top.sv
// self-checking bench for the interrupt, watchdog and halt block
// assumes the core model supplies phase pulses and the rc clock
`timescale 1ns/1ps
module interrupt_watchdog_halt_control_tb_top;
  localparam int T0 = 0, T1 = 1, RTN = 2, CLR = 3, CLR1 = 4, CLR2 = 5, HALT = 6;
  localparam int CALL = 0, CRST = 1, RSM = 2, WARM = 3;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [6:0] pl = 7'h00;
  logic stack_full = 1'b0;
  logic ext_pin_n = 1'b1;
  logic res_pin_n = 1'b1;
  logic [7:0] port_a = 8'hff;
  logic [31:0] rdat, q;
  logic ack, call, crst, warm, stop, res, osc, phase, rc;
  logic [7:0] vec;
  wire [3:0] ev = {warm, res, crst, call};
  int errors = 0;
  int compares = 0;
  int n;

  // ==================================================
  // clock and instances
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  iwh_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .phase_two_pulse_o(phase),
    .wd_rc_osc_o(rc));
  iwh_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .phase_two_pulse_i(phase), .return_from_irq_instr_i(pl[RTN]),
    .clear_watchdog_instr_i(pl[CLR]), .clear_watchdog_first_i(pl[CLR1]),
    .clear_watchdog_second_i(pl[CLR2]), .halt_instr_i(pl[HALT]),
    .stack_full_i(stack_full), .timer0_ovf_i(pl[T0]), .timer1_ovf_i(pl[T1]),
    .ext_irq_pin_n_i(ext_pin_n), .ext_reset_pin_n_i(res_pin_n), .wd_rc_osc_i(rc),
    .port_a_i(port_a), .irq_call_o(call), .irq_vector_o(vec), .chip_reset_o(crst),
    .warm_reset_o(warm), .sys_osc_stop_o(stop), .resume_o(res),
    .osc_output_pin_o(osc));

  // ==================================================
  // shared tasks
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (k >= 50) begin
      errors++;
      $display("unexpected at %0t: bus answer timed out", $time);
      end_sim();
    end
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    pl[i] <= 1'b1;
    @(posedge clk_i);
    pl[i] <= 1'b0;
  endtask

  // n is -1 when the event did not come within the bound
  task automatic wait_ev(input int i, input int bound, input bit must, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      cnt++;
    end while (ev[i] !== 1'b1 && cnt < bound);
    if (ev[i] !== 1'b1) begin
      cnt = -1;
      if (must) begin
        errors++;
        $display("unexpected at %0t: event %0d timed out", $time, i);
        end_sim();
      end
    end
  endtask

  // ==================================================
  // scenarios
  task automatic s_regs();
    wb(1'b1, 8'hf8, 32'h0);
    wb(1'b0, 8'h2c, 32'h0);
    check(q, 32'h0, "control reset");
    wb(1'b0, 8'h24, 32'h0);
    check(q, 32'h07, "select reset");
    wb(1'b1, 8'h24, 32'hfa);
    wb(1'b0, 8'h24, 32'h0);
    check(q, 32'hfa, "select user bits");
    wb(1'b0, 8'h40, 32'h0);
    check(q, 32'h0, "unmapped read");
  endtask

  task automatic s_flags();
    wb(1'b1, 8'h2c, 32'h0e);
    pulse(T0);
    pulse(T1);
    ext_pin_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(1'b0, 8'h2c, 32'h0);
    check(q, 32'h7e, "flags pending");
  endtask

  task automatic s_service();
    stack_full <= 1'b1;
    wb(1'b1, 8'h2c, 32'h7f);
    wait_ev(CALL, 40, 1'b0, n);
    check(32'(n), 32'hffffffff, "call while stack full");
    stack_full <= 1'b0;
    wait_ev(CALL, 20, 1'b1, n);
    check(32'(vec), 32'h04, "first vector");
    wb(1'b0, 8'h2c, 32'h0);
    check(q, 32'h6e, "after external call");
    wait_ev(CALL, 40, 1'b0, n);
    check(32'(n), 32'hffffffff, "call while master off");
    pulse(RTN);
    wait_ev(CALL, 20, 1'b1, n);
    check(32'(vec), 32'h08, "vector after return");
    wb(1'b1, 8'h2c, 32'h4f);
    wait_ev(CALL, 20, 1'b1, n);
    check(32'(vec), 32'h0c, "nested by software");
    wb(1'b0, 8'h2c, 32'h0);
    check(q, 32'h0e, "all served");
  endtask

  task automatic s_watchdog();
    // shortest time-out, so a watchdog that ignores the disable would fire
    wb(1'b1, 8'h24, 32'h00);
    wait_ev(CRST, 3000, 1'b0, n);
    check(32'(n), 32'hffffffff, "disabled watchdog");
    wb(1'b1, 8'hf8, 32'h01);
    pulse(CLR);
    wait_ev(CRST, 1100, 1'b1, n);
    check(32'(n >= 1000 && n <= 1040), 32'h1, "time-out period");
    wb(1'b0, 8'h28, 32'h0);
    check(32'(q[5]), 32'h1, "time-out flag");
    wb(1'b0, 8'h2c, 32'h0);
    check(q, 32'h0, "control after chip reset");
    wb(1'b1, 8'h24, 32'h00);
    wb(1'b1, 8'hf8, 32'h05);
    pulse(CLR1);
    pulse(CLR2);
    repeat (600) @(posedge clk_i);
    pulse(CLR1);
    wait_ev(CRST, 600, 1'b1, n);
    check(32'(n > 0), 32'h1, "half pair does not clear");
    wb(1'b1, 8'h24, 32'h00);
    wb(1'b1, 8'hf8, 32'h01);
    pulse(CLR);
    repeat (700) @(posedge clk_i);
    pulse(CLR);
    wait_ev(CRST, 800, 1'b0, n);
    check(32'(n), 32'hffffffff, "single clear restarts");
  endtask

  task automatic s_halt();
    wb(1'b1, 8'hf8, 32'h0100);
    pulse(HALT);
    repeat (2) @(posedge clk_i);
    check(32'(stop), 32'h1, "oscillator stopped");
    wb(1'b0, 8'h28, 32'h0);
    check(32'(q[5:4]), 32'h1, "halt flags");
    port_a <= 8'hfe;
    wait_ev(RSM, 1100, 1'b1, n);
    check(32'(n >= 1020 && n <= 1040), 32'h1, "wake delay");
    port_a <= 8'hff;
    wb(1'b1, 8'h24, 32'h00);
    wb(1'b1, 8'hf8, 32'h03);
    pulse(HALT);
    wait_ev(WARM, 5600, 1'b1, n);
    wait_ev(RSM, 1100, 1'b1, n);
    wb(1'b0, 8'h28, 32'h0);
    check(32'(q[5:4]), 32'h3, "warm wake flags");
    wb(1'b1, 8'hf8, 32'h08);
    // the pin follows the option one edge after the write lands
    @(posedge clk_i);
    n = 0;
    repeat (8) begin
      @(posedge clk_i);
      n += int'(osc === 1'b1);
    end
    check(32'(n), 32'h4, "divided clock output");
  endtask

  task automatic s_pin_reset();
    wb(1'b1, 8'h24, 32'h00);
    wb(1'b1, 8'hf8, 32'h01);
    pulse(CLR);
    repeat (700) @(posedge clk_i);
    res_pin_n <= 1'b0;
    wait_ev(CRST, 20, 1'b1, n);
    check(32'(n >= 4 && n <= 8), 32'h1, "pin reset delay");
    repeat (10) @(posedge clk_i);
    res_pin_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    // without the clear the old count would expire about 300 cycles on
    wait_ev(CRST, 900, 1'b0, n);
    check(32'(n), 32'hffffffff, "pin reset clears watchdog");
  endtask

  // ==================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    s_regs();
    s_flags();
    s_service();
    s_watchdog();
    s_halt();
    s_pin_reset();
    end_sim();
  end
endmodule

// File: tb/iwh_core_model.sv
// core sequencer model: phase two pulses and the watchdog rc oscillator
// assumes clk_i is the system clock and rst_i a synchronous reset
`timescale 1ns/1ps
module iwh_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // to the block
  output logic phase_two_pulse_o,
  output logic wd_rc_osc_o
);
  // ==================================================
  // machine cycle
  logic [1:0] phase_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_cnt <= 2'h0;
      phase_two_pulse_o <= 1'b0;
    end else begin
      phase_cnt <= phase_cnt + 2'h1;
      phase_two_pulse_o <= (phase_cnt == 2'h1);
    end
  end
  // ==================================================
  // watchdog oscillator
  // free running, also while halted
  initial begin
    wd_rc_osc_o = 1'b0;
    #7;
    forever #200 wd_rc_osc_o = ~wd_rc_osc_o;
  end
endmodule
